//--- verilog/mspi_pkg.sv
// constants for the modem serial register port
package mspi_pkg;
   localparam int          DW          = 16;
   localparam int          AW          = 6;
   localparam int          PW          = 6;
   localparam int          NCFG        = 8;
   localparam logic [3:0]  HDR_LAST    = 4'h7;
   localparam logic [3:0]  WORD_LAST   = 4'hF;
   localparam int          HDR_RD_BIT  = 7;
   localparam int          TX_BANK_BIT = 15;
   localparam logic [5:0]  ADR_SOFT    = 6'h00;
   localparam logic [5:0]  ADR_RX_WIN  = 6'h01;
   localparam logic [5:0]  ADR_TX_WIN  = 6'h02;
   localparam logic [5:0]  ADR_TX_CTL  = 6'h03;
   localparam logic [5:0]  ADR_CCA     = 6'h04;
   localparam logic [5:0]  ADR_IRQ_MSK = 6'h05;
   localparam logic [5:0]  ADR_CTL_A   = 6'h06;
   localparam logic [5:0]  ADR_CTL_B   = 6'h07;
   localparam logic [5:0]  ADR_AMP     = 6'h08;
   localparam logic [5:0]  ADR_CTL_C   = 6'h09;
   localparam logic [5:0]  ADR_CLKO    = 6'h0A;
   localparam logic [15:0] RST_TX_CTL  = 16'h0000;
   localparam logic [15:0] RST_CCA     = 16'h0000;
   localparam logic [15:0] RST_IRQ_MSK = 16'h0000;
   localparam logic [15:0] RST_CTL_A   = 16'h0000;
   localparam logic [15:0] RST_CTL_B   = 16'h0000;
   localparam logic [15:0] RST_AMP     = 16'h0000;
   localparam logic [15:0] RST_CTL_C   = 16'h0000;
   localparam logic [15:0] RST_CLKO    = 16'h0000;
   localparam logic [15:0] CFG_RST [NCFG] = '{RST_TX_CTL, RST_CCA, RST_IRQ_MSK, RST_CTL_A,
                                             RST_CTL_B, RST_AMP, RST_CTL_C, RST_CLKO};
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_HDR  = 4'h2,
      ST_DATA = 4'h4,
      ST_HOLD = 4'h8
   } mspi_state_t;
endpackage : mspi_pkg

//--- verilog/mspi_port.sv
// serial register port of the radio modem, slave side
module mspi_port
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // serial pins
   input  wire logic              sclk,
   input  wire logic              ce_n,
   input  wire logic              mosi,
   output logic                   miso,
   output logic                   miso_oe,
   // core reset
   output logic                   soft_reset_active,
   // register contents
   output logic [mspi_pkg::DW-1:0] tx_packet_control,
   output logic [mspi_pkg::DW-1:0] clear_channel_threshold,
   output logic [mspi_pkg::DW-1:0] interrupt_enable_mask,
   output logic [mspi_pkg::DW-1:0] primary_control,
   output logic [mspi_pkg::DW-1:0] secondary_control,
   output logic [mspi_pkg::DW-1:0] amplifier_enable,
   output logic [mspi_pkg::DW-1:0] tertiary_control,
   output logic [mspi_pkg::DW-1:0] clock_output_control,
   // receive packet RAM fill port
   input  wire logic              rx_ram_we,
   input  wire logic [mspi_pkg::PW-1:0] rx_ram_waddr,
   input  wire logic [mspi_pkg::DW-1:0] rx_ram_wdata,
   // transmit packet RAM read port
   input  wire logic [mspi_pkg::PW-1:0] tx_ram_raddr,
   output logic [mspi_pkg::DW-1:0] tx_ram_rdata
);
   import mspi_pkg::*;

   logic [2:0]        sclk_sy_ff;
   logic [1:0]        ce_sy_ff;
   logic [1:0]        mosi_sy_ff;
   mspi_state_t       state_ff;
   mspi_state_t       nxt_state;
   logic [3:0]        bit_cnt_ff;
   logic [3:0]        nxt_bit_cnt;
   logic [DW-1:0]     shin_ff;
   logic [DW-1:0]     shout_ff;
   logic [AW-1:0]     addr_ff;
   logic              rd_ff;
   logic              soft_rst_ff;
   logic [PW:0]       ptr_ff;
   logic [DW-1:0]     cfg_ff [NCFG];
   logic [DW-1:0]     rx_ram [2**PW];
   logic [DW-1:0]     tx_ram [2**(PW+1)];
   logic [DW-1:0]     tx_rdata_ff;

   wire               sclk_s    = sclk_sy_ff[1];
   wire               sclk_rise = sclk_s & ~sclk_sy_ff[2];
   wire               sclk_fall = ~sclk_s & sclk_sy_ff[2];
   wire               ce_act    = ~ce_sy_ff[1];
   wire               mosi_s    = mosi_sy_ff[1];
   wire               in_hdr    = (state_ff == ST_HDR);
   wire               in_data   = (state_ff == ST_DATA);
   wire               in_hold   = (state_ff == ST_HOLD);
   wire [7:0]         hdr_byte  = {shin_ff[6:0], mosi_s};
   wire               hdr_rd    = hdr_byte[HDR_RD_BIT];
   wire [AW-1:0]      hdr_addr  = hdr_byte[AW-1:0];
   wire               hdr_done  = in_hdr & ce_act & sclk_rise & (bit_cnt_ff == HDR_LAST);
   wire               hdr_soft  = hdr_done & ~hdr_rd & (hdr_addr == ADR_SOFT);
   wire               word_done = in_data & ce_act & sclk_rise & (bit_cnt_ff == WORD_LAST);
   wire [DW-1:0]      word_in   = {shin_ff[DW-2:0], mosi_s};
   wire               core_rst  = ~resetn | soft_rst_ff;
   wire [AW-1:0]      sel_addr  = in_hdr ? hdr_addr : addr_ff;
   wire               sel_cfg   = (sel_addr >= ADR_TX_CTL) & (sel_addr <= ADR_CLKO);
   wire [AW-1:0]      sel_off   = sel_addr - ADR_TX_CTL;
   wire               ptr_ok    = ~ptr_ff[PW];
   wire               tx_bank   = cfg_ff[0][TX_BANK_BIT];
   wire               rx_step   = word_done & rd_ff & (addr_ff == ADR_RX_WIN) & ptr_ok;
   wire               tx_step   = word_done & ~rd_ff & (addr_ff == ADR_TX_WIN) & ptr_ok;
   wire               cfg_wr    = word_done & ~rd_ff & (addr_ff >= ADR_TX_CTL) & (addr_ff <= ADR_CLKO);
   wire [AW-1:0]      wr_off    = addr_ff - ADR_TX_CTL;
   wire               load_out  = hdr_done | (word_done & rd_ff);
   // first window word is a dummy: the RAM is not reached yet
   wire [DW-1:0]      rx_word   = (in_hdr | ~ptr_ok) ? '0 : rx_ram[ptr_ff[PW-1:0]];
   wire [DW-1:0]      rd_data   = (sel_addr == ADR_RX_WIN) ? rx_word :
                                  sel_cfg ? cfg_ff[sel_off[2:0]] : '0;

   assign miso              = shout_ff[DW-1];
   assign miso_oe           = in_data & rd_ff & ce_act;
   assign soft_reset_active = soft_rst_ff;
   assign tx_packet_control       = cfg_ff[0];
   assign clear_channel_threshold = cfg_ff[1];
   assign interrupt_enable_mask   = cfg_ff[2];
   assign primary_control         = cfg_ff[3];
   assign secondary_control       = cfg_ff[4];
   assign amplifier_enable        = cfg_ff[5];
   assign tertiary_control        = cfg_ff[6];
   assign clock_output_control    = cfg_ff[7];
   assign tx_ram_rdata            = tx_rdata_ff;

   // pins are asynchronous to clk, two stages before use
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sclk_sy_ff <= 3'h0;
         ce_sy_ff   <= 2'h3;
         mosi_sy_ff <= 2'h0;
      end
      else
      begin
         sclk_sy_ff <= {sclk_sy_ff[1:0], sclk};
         ce_sy_ff   <= {ce_sy_ff[0], ce_n};
         mosi_sy_ff <= {mosi_sy_ff[0], mosi};
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (ce_act) nxt_state = ST_HDR;
         ST_HDR:
         begin
            if (!ce_act) nxt_state = ST_IDLE;
            else if (hdr_soft) nxt_state = ST_HOLD;
            else if (hdr_done) nxt_state = ST_DATA;
         end
         ST_DATA: if (!ce_act) nxt_state = ST_IDLE;
         ST_HOLD: if (!ce_act) nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // bit counter wraps per 16-bit word so recursive bursts keep framing
   always_comb
   begin
      nxt_bit_cnt = bit_cnt_ff;
      if (!ce_act || !(in_hdr || in_data) || hdr_done)
         nxt_bit_cnt = 4'h0;
      else if (sclk_rise)
         nxt_bit_cnt = bit_cnt_ff + 4'h1;
   end

   // port state answers only to the pin reset, else soft reset could not end
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         soft_rst_ff <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         bit_cnt_ff  <= nxt_bit_cnt;
         if (hdr_soft)
            soft_rst_ff <= 1'b1;
         else if (in_hold && !ce_act)
            soft_rst_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         shin_ff  <= '0;
         addr_ff  <= '0;
         rd_ff    <= 1'b0;
      end
      else
      begin
         if (sclk_rise && (in_hdr || in_data))
            shin_ff <= word_in;
         if (hdr_done)
         begin
            addr_ff <= hdr_addr;
            rd_ff   <= hdr_rd;
         end
      end
   end

   // shift out on falling edges, except the one right after a load
   always_ff @(posedge clk)
   begin
      if (!resetn)
         shout_ff <= '0;
      else if (load_out)
         shout_ff <= rd_data;
      else if (sclk_fall && in_data && bit_cnt_ff != 4'h0)
         shout_ff <= {shout_ff[DW-2:0], 1'b0};
   end

   // window pointer; register address never advances
   always_ff @(posedge clk)
   begin
      if (core_rst || hdr_done)
         ptr_ff <= '0;
      else if (rx_step || tx_step)
         ptr_ff <= ptr_ff + 1'b1;
   end

   generate
      for (genvar i = 0; i < NCFG; i++)
      begin : g_cfg
         always_ff @(posedge clk)
         begin
            if (core_rst)
               cfg_ff[i] <= CFG_RST[i];
            else if (cfg_wr && wr_off[2:0] == 3'(i))
               cfg_ff[i] <= word_in;
         end
      end
   endgenerate

   // packet RAMs have no reset so soft reset leaves them intact
   always_ff @(posedge clk)
   begin
      if (rx_ram_we)
         rx_ram[rx_ram_waddr] <= rx_ram_wdata;
      if (tx_step && !soft_rst_ff)
         tx_ram[{tx_bank, ptr_ff[PW-1:0]}] <= word_in;
      tx_rdata_ff <= tx_ram[{tx_bank, tx_ram_raddr}];
   end

   sequence s_soft_hdr;
      hdr_soft;
   endsequence

   sequence s_held_low;
      soft_rst_ff && ce_act;
   endsequence

   property p_soft_assert;
      @(posedge clk) disable iff (!resetn)
      s_soft_hdr |=> soft_rst_ff && in_hold;
   endproperty

   property p_soft_defaults;
      @(posedge clk) disable iff (!resetn)
      s_soft_hdr ##1 soft_rst_ff |=> tx_packet_control == RST_TX_CTL && primary_control == RST_CTL_A
                                     && clock_output_control == RST_CLKO;
   endproperty

   a_soft_reset_set: assert property (p_soft_assert)
      else $error("soft reset did not follow write header to zero");
   a_soft_reset_dflt: assert property (p_soft_defaults)
      else $error("registers not at defaults during soft reset");
   a_soft_reset_hold: assert property (@(posedge clk) disable iff (!resetn)
      s_held_low |=> soft_rst_ff)
      else $error("soft reset dropped while chip enable low");
   a_soft_reset_end: assert property (@(posedge clk) disable iff (!resetn)
      soft_rst_ff && !ce_act |=> !soft_rst_ff ##1 state_ff == ST_IDLE || ce_act)
      else $error("soft reset outlived chip enable");
   a_read_zero_safe: assert property (@(posedge clk) disable iff (!resetn)
      hdr_done && hdr_rd |=> !soft_rst_ff && in_data)
      else $error("read header caused soft reset");
   a_hold_ignores: assert property (@(posedge clk) disable iff (!resetn)
      s_held_low ##1 sclk_rise |-> in_hold && $stable(cfg_ff[3]))
      else $error("serial data taken while soft reset held");
   a_window_advance: assert property (@(posedge clk) disable iff (!resetn)
      rx_step && !soft_rst_ff |=> ptr_ff == $past(ptr_ff) + 1'b1 && addr_ff == $past(addr_ff))
      else $error("window pointer or address wrong after word");
   a_cfg_msb_first: assert property (@(posedge clk) disable iff (!resetn)
      cfg_wr && addr_ff == ADR_CTL_A && !soft_rst_ff |=> primary_control == $past(word_in))
      else $error("register write not assembled msb first");
   a_data_after_hdr: assert property (@(posedge clk) disable iff (!resetn)
      $rose(in_data) |-> $past(hdr_done) && !$past(hdr_soft))
      else $error("data phase without a header");
endmodule : mspi_port

//--- test/mspi_host.sv
// host serial master model for the modem register port
module mspi_host
(
   // clock
   input  wire logic clk,
   // serial pins
   output logic      sclk,
   output logic      ce_n,
   output logic      mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   // clk cycles per sclk phase; port needs >=3 for its synchronisers
   localparam int HALF = 5;
   initial
   begin
      sclk = 1'b0;
      ce_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk
   task automatic start;
      ce_n = 1'b0;
      wait_clk(HALF);
   endtask : start
   // msb first, miso taken at each rising sclk
   task automatic shift(input logic [15:0] w, input int n, output logic [15:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi = w[i];
         wait_clk(HALF);
         sclk = 1'b1;
         r = {r[14:0], miso};
         wait_clk(HALF);
         sclk = 1'b0;
      end
   endtask : shift
   task automatic stop;
      wait_clk(HALF);
      ce_n = 1'b1;
      // a released line must not keep its last level
      mosi = ~mosi;
      wait_clk(HALF);
   endtask : stop
   task automatic xfer(input logic [7:0] hdr, input logic [15:0] w, output logic [15:0] r);
      logic [15:0] dummy;
      start();
      shift({8'h00, hdr}, 8, dummy);
      shift(w, 16, r);
      stop();
   endtask : xfer
endmodule : mspi_host

//--- test/tb.sv
// self-checking bench for the modem serial register port
module tb;
   import mspi_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk, resetn, sclk, ce_n, mosi, miso, miso_oe, soft_reset_active;
   logic          rx_ram_we;
   logic [PW-1:0] rx_ram_waddr, tx_ram_raddr;
   logic [DW-1:0] rx_ram_wdata, tx_ram_rdata, r;
   logic [DW-1:0] regs [NCFG];
   int            n_errors, checked, cycles;

   mspi_port dut (.clk(clk), .resetn(resetn), .sclk(sclk), .ce_n(ce_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .soft_reset_active(soft_reset_active), .tx_packet_control(regs[0]),
      .clear_channel_threshold(regs[1]), .interrupt_enable_mask(regs[2]), .primary_control(regs[3]),
      .secondary_control(regs[4]), .amplifier_enable(regs[5]), .tertiary_control(regs[6]),
      .clock_output_control(regs[7]), .rx_ram_we(rx_ram_we), .rx_ram_waddr(rx_ram_waddr),
      .rx_ram_wdata(rx_ram_wdata), .tx_ram_raddr(tx_ram_raddr), .tx_ram_rdata(tx_ram_rdata));
   mspi_host h (.clk(clk), .sclk(sclk), .ce_n(ce_n), .mosi(mosi), .miso(miso));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // whole run is about 7100 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         $display("[FAIL] %0t run timed out", $time);
         conclude();
      end
   end

   initial
   begin
      resetn = 1'b0;
      rx_ram_we = 1'b0;
      rx_ram_waddr = '0;
      rx_ram_wdata = '0;
      tx_ram_raddr = '0;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < NCFG; i++)
         check(regs[i], CFG_RST[i], "reset value");
      check({15'h0000, miso_oe}, 16'h0000, "idle drive");
      $display("test reset values done");
      // bit 15 kept low so the tx bank stays put
      for (int i = 0; i < NCFG; i++)
      begin
         h.xfer({2'b00, ADR_TX_CTL + 6'(i)}, 16'h5A3C ^ (16'(i) << 8), r);
         check(regs[i], 16'h5A3C ^ (16'(i) << 8), "port value");
         h.xfer({2'b10, ADR_TX_CTL + 6'(i)}, 16'h0000, r);
         check(r, 16'h5A3C ^ (16'(i) << 8), "read back");
      end
      $display("test write and read done");
      h.xfer(8'h80, 16'hFFFF, r);
      check(r, 16'h0000, "zero read");
      check(regs[3], 16'h593C, "no reset on read");
      $display("test read of zero done");
      for (int i = 0; i < 2; i++)
      begin
         @(negedge clk);
         rx_ram_we = 1'b1;
         rx_ram_waddr = 6'(i);
         rx_ram_wdata = 16'hC3A0 + 16'(i);
      end
      @(negedge clk);
      rx_ram_we = 1'b0;
      h.start();
      h.shift(16'h0002, 8, r);
      h.shift(16'h1234, 16, r);
      h.shift(16'hBEEF, 16, r);
      h.stop();
      h.start();
      h.shift(16'h0000, 8, r);
      check({15'h0000, soft_reset_active}, 16'h0001, "reset after header");
      h.shift(16'h0006, 16, r);
      check({15'h0000, soft_reset_active}, 16'h0001, "reset held");
      check({15'h0000, miso_oe}, 16'h0000, "no drive in hold");
      for (int i = 0; i < NCFG; i++)
         check(regs[i], CFG_RST[i], "soft reset value");
      h.stop();
      check({15'h0000, soft_reset_active}, 16'h0000, "reset released");
      for (int i = 0; i < 2; i++)
      begin
         @(negedge clk);
         tx_ram_raddr = 6'(i);
         repeat (2) @(negedge clk);
         check(tx_ram_rdata, i == 0 ? 16'h1234 : 16'hBEEF, "tx ram kept");
      end
      h.start();
      h.shift(16'h0081, 8, r);
      check({15'h0000, miso_oe}, 16'h0001, "drive on read");
      h.shift(16'h0000, 16, r);
      check(r, 16'h0000, "dummy word");
      for (int i = 0; i < 2; i++)
      begin
         h.shift(16'h0000, 16, r);
         check(r, 16'hC3A0 + 16'(i), "rx ram kept");
      end
      h.stop();
      check({15'h0000, miso_oe}, 16'h0000, "drive released");
      h.xfer({2'b00, ADR_CTL_A}, 16'h8001, r);
      check(regs[3], 16'h8001, "fresh write");
      $display("test soft reset done");
      // partial update keeps the other bits
      h.xfer({2'b10, ADR_CTL_A}, 16'h0000, r);
      check(r, 16'h8001, "modify read");
      h.xfer({2'b00, ADR_CTL_A}, r | 16'h0010, r);
      check(regs[3], 16'h8011, "modify write");
      // over-programming lands outside this port's map and must be ignored
      h.xfer({2'b00, 6'h31}, 16'hA0C0, r);
      h.xfer({2'b00, 6'h34}, 16'hFEC6, r);
      check(regs[6], CFG_RST[6], "unmapped write 31");
      check(regs[1], CFG_RST[1], "unmapped write 34");
      check(regs[3], 16'h8011, "unmapped write kept");
      h.xfer({2'b10, 6'h31}, 16'h0000, r);
      check(r, 16'h0000, "unmapped read");
      $display("test host sequences done");
      conclude();
   end
endmodule : tb
